/* File: bench/floppy_result_status_props.sv */
// Assertions on the result status ports, bound to the block
`timescale 1ns/1ps
`include "fdc_status_map.svh"
module floppy_result_status_props (
	input wire logic       i_clk,                    // Clock
	input wire logic       i_nrst,                   // Reset, active low
	input wire logic       i_cmd_end,                // Execution done
	input wire logic       i_invalid,                // Invalid command
	input wire logic       i_poll_abort,             // Polling stop
	input wire logic       i_head,                   // Head
	input wire logic [1:0] i_drive,                  // Drive
	input wire logic       i_rd_data,                // Host read
	input wire logic       o_request_for_master_bit, // Host may read
	input wire logic       o_transfer_direction_bit, // Direction
	input wire logic [7:0] o_data,                   // Data port
	input wire logic [7:0] o_result_status_zero,     // Byte zero
	input wire logic [7:0] o_result_status_one,      // Byte one
	input wire logic [7:0] o_result_status_two       // Byte two
);
	logic       rq;
	logic       flags;
	logic [1:0] reads;
	logic [7:0] s0, s1, s2;
	assign rq = o_request_for_master_bit;
	assign s0 = o_result_status_zero;
	assign s1 = o_result_status_one;
	assign s2 = o_result_status_two;
	// Latched faults that make an ending abnormal
	assign flags = (s1 != 8'h00) || s0[4] || s2[4] || s2[0];
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst)
			reads <= 2'h0;
		else if (!rq)
			reads <= 2'h0;
		else if (i_rd_data)
			reads <= reads + 2'h1;
	end
	sequence result_opens;
		$rose(rq);
	endsequence
	sequence zero_shown;
		##1 o_data == s0;
	endsequence
	chk_open_cause: assert property (result_opens |-> $past(i_cmd_end))
		else $error("result phase opened without end of execution");
	chk_first_byte: assert property (result_opens |-> zero_shown)
		else $error("byte zero not presented first");
	chk_next_byte: assert property (rq && i_rd_data && reads != 2'h2 |=>
		o_data == ($past(reads) == 2'h0 ? s1 : s2))
		else $error("wrong byte after a read");
	chk_last_read: assert property (rq && i_rd_data && reads == 2'h2 |=> !rq)
		else $error("request still up after third read");
	chk_dir_match: assert property (rq == o_transfer_direction_bit)
		else $error("direction differs from request");
	chk_unused_zero: assert property ({s0[3], s1[6], s1[3], s2[7], s2[3:2]} == 6'h00)
		else $error("unused status bit set");
	chk_term_code: assert property (result_opens |-> s0[7:6] ==
		($past(i_invalid) ? `TERM_INVALID : $past(i_poll_abort) ? `TERM_POLLING :
		flags ? `TERM_ABNORMAL : `TERM_NORMAL))
		else $error("termination code wrong");
	chk_head_drive: assert property (result_opens |->
		s0[2] == $past(i_head) && s0[1:0] == $past(i_drive))
		else $error("head or drive field wrong");
	chk_bytes_hold: assert property (rq && $past(rq) |->
		$stable(s0) && $stable(s1) && $stable(s2))
		else $error("status bytes changed during result phase");
	chk_bad_track: assert property (s2[1] |-> s2[4])
		else $error("bad track without track mismatch");
	chk_crc_pair: assert property (s2[5] |-> s1[5])
		else $error("data field crc without crc fault");
endmodule

bind floppy_result_status floppy_result_status_props chk (
	.i_clk, .i_nrst, .i_cmd_end, .i_invalid, .i_poll_abort, .i_head, .i_drive, .i_rd_data,
	.o_request_for_master_bit, .o_transfer_direction_bit, .o_data,
	.o_result_status_zero, .o_result_status_one, .o_result_status_two
);

/* File: bench/floppy_result_status_test.sv */
// Self-checking bench for the result status byte assembly
`timescale 1ns/1ps
module floppy_result_status_test;
	import fdc_status_pkg::*;
	logic i_clk = 1'b0, i_nrst = 1'b0, i_cmd_start = 1'b0, i_cmd_end = 1'b0, i_invalid = 1'b0;
	logic i_poll_abort = 1'b0, i_terminal_count_input = 1'b0, i_recal = 1'b0;
	logic i_head, i_rd_data, o_request_for_master_bit, o_transfer_direction_bit;
	logic [1:0]      i_drive, cnt;
	logic [2:0]      hd = 3'h0;
	logic [7:0]      i_track = 8'h05;
	logic [7:0]      o_data, o_result_status_zero, o_result_status_one, o_result_status_two;
	logic [2:0][7:0] got;
	cmd_class_t      i_cmd_class = CMD_SEEK;
	disk_events_t    i_ev = '0;
	int              n_fail = 0;
	int              compares = 0;
	assign {i_head, i_drive} = hd;
	always #2.5 i_clk = ~i_clk;

	floppy_result_status dut (
		.i_clk, .i_nrst, .i_cmd_start, .i_cmd_class, .i_cmd_end, .i_invalid, .i_poll_abort,
		.i_terminal_count_input, .i_head, .i_drive, .i_track, .i_recal, .i_ev, .i_rd_data,
		.o_request_for_master_bit, .o_transfer_direction_bit, .o_data,
		.o_result_status_zero, .o_result_status_one, .o_result_status_two
	);
	host_reader host (
		.i_clk(i_clk), .i_ready(o_request_for_master_bit), .i_outbound(o_transfer_direction_bit),
		.i_data(o_data), .i_slow(hd[1:0]), .o_rd(i_rd_data), .o_bytes(got), .o_count(cnt)
	);

	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic summarize;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// One command: start, n event pulses, end, then the host drains three bytes
	task automatic run(input cmd_class_t c, input disk_events_t e, input int n, input logic t,
			input logic [1:0] ip, input logic [7:0] e0, input logic [7:0] e1, input logic [7:0] e2);
		int i;
		@(negedge i_clk);
		i_cmd_start = 1'b1;
		i_cmd_class = c;
		@(negedge i_clk);
		i_cmd_start = 1'b0;
		i_terminal_count_input = t;
		i_recal = e.recal_step;
		for (i = 0; i < n; i++) begin
			i_ev = e;
			@(negedge i_clk);
			i_ev = '0;
			@(negedge i_clk);
		end
		repeat (4) @(negedge i_clk);
		i_cmd_end = 1'b1;
		{i_invalid, i_poll_abort} = ip;
		@(negedge i_clk);
		{i_cmd_end, i_invalid, i_poll_abort, i_terminal_count_input, i_recal} = 5'h00;
		repeat (2) @(negedge i_clk);
		for (i = 0; i < 60 && (cnt != 2'h3 || o_request_for_master_bit); i++)
			@(negedge i_clk);
		if (i == 60) begin
			n_fail++;
			summarize();
		end
		e0 = e0 | {5'h00, hd};
		check("byte0", got[0], e0);
		check("byte1", got[1], e1);
		check("byte2", got[2], e2);
		check("reg0", o_result_status_zero, e0);
		check("reg1", o_result_status_one, e1);
		check("reg2", o_result_status_two, e2);
		hd = hd + 3'h1;
	endtask

	initial begin
		repeat (3) @(negedge i_clk);
		i_nrst = 1'b1;
		run(CMD_READ_DATA, '0, 0, 1'h1, 2'h0, 8'h00, 8'h00, 8'h00);
		run(CMD_READ_DATA, '0, 0, 1'h0, 2'h0, 8'h40, 8'h80, 8'h00);
		run(CMD_SEEK, '{default: 1'h0, seek_complete: 1'h1}, 1, 1'h1, 2'h0, 8'h20, 8'h00, 8'h00);
		run(CMD_SEEK, '0, 0, 1'h1, 2'h3, 8'h80, 8'h00, 8'h00);
		run(CMD_SEEK, '0, 0, 1'h1, 2'h1, 8'hC0, 8'h00, 8'h00);
		run(CMD_SEEK, '{default: 1'h0, recal_step: 1'h1}, 80, 1'h1, 2'h0, 8'h50, 8'h00, 8'h00);
		run(CMD_SEEK, '{default: 1'h0, recal_step: 1'h1}, 79, 1'h1, 2'h0, 8'h00, 8'h00, 8'h00);
		run(CMD_SEEK, '{default: 1'h0, relseek_underflow: 1'h1}, 1, 1'h1, 2'h0,
			8'h50, 8'h00, 8'h00);
		run(CMD_READ_DATA, '{default: 1'h0, id_crc_error: 1'h1}, 1, 1'h1, 2'h0,
			8'h40, 8'h20, 8'h00);
		run(CMD_READ_DATA, '{default: 1'h0, data_crc_error: 1'h1}, 1, 1'h1, 2'h0,
			8'h40, 8'h20, 8'h20);
		run(CMD_READ_DATA, '{default: 1'h0, overrun: 1'h1}, 1, 1'h1, 2'h0, 8'h40, 8'h10, 8'h00);
		run(CMD_READ_DELETED, '{default: 1'h0, sector_missing: 1'h1}, 1, 1'h1, 2'h0,
			8'h40, 8'h04, 8'h00);
		run(CMD_READ_TRACK, '{default: 1'h0, bad_sequence: 1'h1}, 1, 1'h1, 2'h0,
			8'h40, 8'h04, 8'h00);
		run(CMD_READ_ID, '{default: 1'h0, id_crc_error: 1'h1}, 1, 1'h1, 2'h0,
			8'h40, 8'h24, 8'h00);
		run(CMD_READ_DATA, '{default: 1'h0, id_valid: 1'h1, id_track: 8'h05, sector_number: 8'hFF},
			1, 1'h1, 2'h0, 8'h40, 8'h80, 8'h00);
		run(CMD_WRITE_DATA, '{default: 1'h0, write_protect: 1'h1}, 1, 1'h1, 2'h0,
			8'h40, 8'h02, 8'h00);
		run(CMD_FORMAT, '{default: 1'h0, write_protect: 1'h1}, 1, 1'h1, 2'h0,
			8'h40, 8'h02, 8'h00);
		run(CMD_READ_DATA, '{default: 1'h0, write_protect: 1'h1}, 1, 1'h1, 2'h0,
			8'h00, 8'h00, 8'h00);
		run(CMD_READ_DATA, '{default: 1'h0, index_pulse_input: 1'h1}, 2, 1'h1, 2'h0,
			8'h40, 8'h01, 8'h00);
		run(CMD_READ_DATA, '{default: 1'h0, index_pulse_input: 1'h1}, 1, 1'h1, 2'h0,
			8'h00, 8'h00, 8'h00);
		run(CMD_READ_DATA, '{default: 1'h0, data_mark_absent: 1'h1}, 1, 1'h1, 2'h0,
			8'h40, 8'h01, 8'h01);
		run(CMD_READ_DATA, '{default: 1'h0, deleted_mark_seen: 1'h1}, 1, 1'h1, 2'h0,
			8'h00, 8'h00, 8'h40);
		run(CMD_READ_DELETED, '{default: 1'h0, normal_mark_seen: 1'h1}, 1, 1'h1, 2'h0,
			8'h00, 8'h00, 8'h40);
		run(CMD_READ_DATA, '{default: 1'h0, id_valid: 1'h1, id_track: 8'h07, sector_number: 8'h01},
			1, 1'h1, 2'h0, 8'h40, 8'h00, 8'h10);
		run(CMD_READ_DATA, '{default: 1'h0, id_valid: 1'h1, id_track: 8'hFF, sector_number: 8'h01},
			1, 1'h1, 2'h0, 8'h40, 8'h00, 8'h12);
		// Reset in the result phase, then one clean command
		@(negedge i_clk);
		i_cmd_start = 1'b1;
		@(negedge i_clk);
		{i_cmd_start, i_cmd_end} = 2'h1;
		@(negedge i_clk);
		{i_cmd_end, i_nrst} = 2'h0;
		repeat (3) @(negedge i_clk);
		check("rst_req", {7'h00, o_request_for_master_bit}, 8'h00);
		check("rst_reg1", o_result_status_one, 8'h00);
		i_nrst = 1'b1;
		run(CMD_READ_DATA, '0, 0, 1'h1, 2'h0, 8'h00, 8'h00, 8'h00);
		summarize();
	end
endmodule

/* File: bench/host_reader.sv */
// Host model that drains result bytes when the controller asks
`timescale 1ns/1ps
module host_reader (
	input  wire logic       i_clk,   // Controller clock
	input  wire logic       i_ready,    // Host may transfer
	input  wire logic       i_outbound, // Device to host
	input  wire logic [7:0] i_data,  // Data port
	input  wire logic [1:0] i_slow,  // Extra idle cycles per read
	output logic            o_rd,    // Read strobe
	output logic [2:0][7:0] o_bytes, // Bytes read, in order
	output logic [1:0]      o_count  // Bytes read this phase
);
	logic       ready_q = 1'b0;
	logic [2:0] idle = 3'h0;
	initial begin
		o_rd = 1'b0;
		o_count = 2'h0;
		o_bytes = '0;
	end
	// Byte is taken at the edge that samples the strobe
	always @(posedge i_clk) begin
		ready_q <= i_ready;
		if (i_ready && !ready_q)
			o_count <= 2'h0;
		else if (o_rd) begin
			o_bytes[o_count] <= i_data;
			o_count <= o_count + 2'h1;
		end
		idle <= (o_rd || !(i_ready && i_outbound)) ? 3'h0 : idle + 3'h1;
	end
	// Strobe only while ready and outbound, one cycle each
	always @(negedge i_clk)
		o_rd <= i_ready && i_outbound && !o_rd && o_count != 2'h3 && idle > {1'b0, i_slow};
endmodule

/* File: core/fdc_status_map.svh */
// Bit positions, codes and constants of the result status bytes
`ifndef FDC_STATUS_MAP_SVH
`define FDC_STATUS_MAP_SVH
`define TERM_NORMAL      2'h0
`define TERM_ABNORMAL    2'h1
`define TERM_INVALID     2'h2
`define TERM_POLLING     2'h3
`define RECAL_STEP_LIMIT 8'h50
`define LAST_SECTOR      8'hFF
`define BAD_TRACK_ID     8'hFF
`define RESULT_COUNT     2'h3
`define INDEX_MISS_LIMIT 2'h2
`define TERM_FIELD       7:6
`define BIT_HEAD         2
`define DRIVE_FIELD      1:0
`define BIT_SEEK_DONE    5
`define BIT_EQUIP        4
`define BIT_END_CYL      7
`define BIT_CRC          5
`define BIT_OVERRUN      4
`define BIT_NO_SECTOR    2
`define BIT_WRITE_BLK    1
`define BIT_MARK_ABSENT  0
`define BIT_CTRL_MARK    6
`define BIT_DATA_CRC     5
`define BIT_TRACK_MISM   4
`define BIT_BAD_TRACK    1
`define BIT_DATA_MARK    0
`endif

/* File: core/fdc_status_pkg.sv */
// Types shared by the result status logic
package fdc_status_pkg;
	typedef enum logic [2:0] {
		CMD_READ_DATA,
		CMD_READ_DELETED,
		CMD_WRITE_DATA,
		CMD_WRITE_DELETED,
		CMD_FORMAT,
		CMD_READ_ID,
		CMD_READ_TRACK,
		CMD_SEEK
	} cmd_class_t;

	typedef struct packed {
		logic       recal_step;
		logic       track_zero_input;
		logic       relseek_underflow;
		logic       seek_complete;
		logic       index_pulse_input;
		logic       id_mark_found;
		logic       id_crc_error;
		logic       data_crc_error;
		logic       data_mark_absent;
		logic       deleted_mark_seen;
		logic       normal_mark_seen;
		logic       overrun;
		logic       sector_missing;
		logic       bad_sequence;
		logic       write_protect;
		logic       id_valid;
		logic [7:0] id_track;
		logic [7:0] sector_number;
	} disk_events_t;

	typedef struct packed {
		logic [7:0] zero;
		logic [7:0] one;
		logic [7:0] two;
	} status_bytes_t;
endpackage

/* File: core/floppy_result_status.sv */
// Result phase status byte assembly for the floppy controller core
`timescale 1ns/1ps
`include "fdc_status_map.svh"
module floppy_result_status
	import fdc_status_pkg::*;
(
	input  wire logic         i_clk,         // Controller clock, 200 MHz
	input  wire logic         i_nrst,        // Async reset, active low
	input  wire logic         i_cmd_start,   // Pulse: command execution begins
	input  wire cmd_class_t   i_cmd_class,   // Class of command starting
	input  wire logic         i_cmd_end,     // Pulse: execution finished
	input  wire logic         i_invalid,     // Command could not be executed
	input  wire logic         i_poll_abort,  // Command stopped by drive polling
	input  wire logic         i_terminal_count_input, // Terminal count seen
	input  wire logic         i_head,        // Current head address
	input  wire logic [1:0]   i_drive,       // Selected drive number
	input  wire logic [7:0]   i_track,       // Internal track number
	input  wire logic         i_recal,       // Recalibrate in progress
	input  wire disk_events_t i_ev,          // Disk side events and pin levels
	input  wire logic         i_rd_data,     // Host read strobe of data port
	output logic              o_request_for_master_bit,  // Host may read
	output logic              o_transfer_direction_bit,  // Direction: device to host
	output logic [7:0]        o_data,        // Result byte on data port
	output logic [7:0]        o_result_status_zero,      // Latched byte zero
	output logic [7:0]        o_result_status_one,       // Latched byte one
	output logic [7:0]        o_result_status_two        // Latched byte two
);
	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_RESULT} phase_t;

	phase_t        phase;
	cmd_class_t    cmd_class;
	logic [1:0]    rd_index;
	logic [1:0]    wp_sync;
	logic [1:0]    tz_sync;
	logic [1:0]    index_sync;
	logic          wp_prev;
	logic          index_prev;
	logic [1:0]    index_count;
	logic          recal_fault;
	logic          term_count_seen;
	logic          any_error;
	logic          end_cyl_now;
	logic [7:0]    st0;
	logic [7:0]    st1;
	logic [7:0]    st2;
	status_bytes_t next_bytes;
	logic          seek_done_flag;
	logic          equipment_fault_flag;
	logic          end_cylinder_flag;
	logic          crc_fault_flag;
	logic          overrun_flag;
	logic          sector_not_found_flag;
	logic          write_blocked_flag;
	logic          mark_absent_flag;
	logic          control_mark_flag;
	logic          data_field_crc_flag;
	logic          track_mismatch_flag;
	logic          bad_track_flag;
	logic          data_mark_absent_flag;

	function automatic logic is_write(input cmd_class_t c);
		return c == CMD_WRITE_DATA || c == CMD_WRITE_DELETED || c == CMD_FORMAT;
	endfunction

	function automatic logic is_read(input cmd_class_t c);
		return c == CMD_READ_DATA || c == CMD_READ_DELETED;
	endfunction

	// Pin levels pass two flip-flops before use
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			wp_sync  <= 2'h0;
			tz_sync  <= 2'h0;
			index_sync <= 2'h0;
			wp_prev    <= 1'b0;
			index_prev <= 1'b0;
		end else begin
			wp_sync  <= {wp_sync[0], i_ev.write_protect};
			tz_sync  <= {tz_sync[0], i_ev.track_zero_input};
			index_sync <= {index_sync[0], i_ev.index_pulse_input};
			wp_prev    <= wp_sync[1];
			index_prev <= index_sync[1];
		end
	end

	recal_step_counter u_recal (
		.i_clk        (i_clk),
		.i_nrst       (i_nrst),
		.i_clear      (i_cmd_start),
		.i_recal      (i_recal),
		.i_step       (i_ev.recal_step),
		.i_track_zero (tz_sync[1]),
		.o_fault      (recal_fault)
	);

	// Phase tracking and result byte pointer
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			phase     <= ST_IDLE;
			cmd_class <= CMD_SEEK;
			rd_index  <= 2'h0;
		end else begin
			case (phase)
				ST_IDLE: begin
					if (i_cmd_start) begin
						phase     <= ST_EXEC;
						cmd_class <= i_cmd_class;
					end
				end
				ST_EXEC: begin
					if (i_cmd_end) begin
						phase    <= ST_RESULT;
						rd_index <= 2'h0;
					end
				end
				ST_RESULT: begin
					if (i_rd_data) begin
						if (rd_index == `RESULT_COUNT - 2'h1) begin
							phase <= ST_IDLE;
						end
						rd_index <= rd_index + 2'h1;
					end
				end
				default: phase <= ST_IDLE;
			endcase
		end
	end

	// Index pulses counted while no ID mark is found
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			index_count <= 2'h0;
		end else if ((i_cmd_start && phase == ST_IDLE) || i_ev.id_mark_found) begin
			index_count <= 2'h0;
		end else if (phase == ST_EXEC && index_sync[1] && !index_prev &&
				index_count != `INDEX_MISS_LIMIT) begin
			index_count <= index_count + 2'h1;
		end
	end

	// Sticky flags: new command clears, events set during execution; clear wins over set
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			seek_done_flag        <= 1'b0;
			equipment_fault_flag  <= 1'b0;
			end_cylinder_flag     <= 1'b0;
			crc_fault_flag        <= 1'b0;
			overrun_flag          <= 1'b0;
			sector_not_found_flag <= 1'b0;
			write_blocked_flag    <= 1'b0;
			mark_absent_flag      <= 1'b0;
			control_mark_flag     <= 1'b0;
			data_field_crc_flag   <= 1'b0;
			track_mismatch_flag   <= 1'b0;
			bad_track_flag        <= 1'b0;
			data_mark_absent_flag <= 1'b0;
			term_count_seen       <= 1'b0;
		end else if (i_cmd_start && phase == ST_IDLE) begin
			seek_done_flag        <= 1'b0;
			equipment_fault_flag  <= 1'b0;
			end_cylinder_flag     <= 1'b0;
			crc_fault_flag        <= 1'b0;
			overrun_flag          <= 1'b0;
			sector_not_found_flag <= 1'b0;
			write_blocked_flag    <= 1'b0;
			mark_absent_flag      <= 1'b0;
			control_mark_flag     <= 1'b0;
			data_field_crc_flag   <= 1'b0;
			track_mismatch_flag   <= 1'b0;
			bad_track_flag        <= 1'b0;
			data_mark_absent_flag <= 1'b0;
			term_count_seen       <= 1'b0;
		end else if (phase == ST_EXEC) begin
			if (i_ev.seek_complete)
				seek_done_flag <= 1'b1;
			if (recal_fault || i_ev.relseek_underflow)
				equipment_fault_flag <= 1'b1;
			if (i_terminal_count_input)
				term_count_seen <= 1'b1;
			if (i_ev.sector_number == `LAST_SECTOR && i_ev.id_valid && !term_count_seen)
				end_cylinder_flag <= 1'b1;
			if (end_cyl_now)
				end_cylinder_flag <= 1'b1;
			if (i_ev.id_crc_error || i_ev.data_crc_error)
				crc_fault_flag <= 1'b1;
			if (i_ev.overrun)
				overrun_flag <= 1'b1;
			if ((is_read(cmd_class) && i_ev.sector_missing) ||
					(cmd_class == CMD_READ_ID && i_ev.id_crc_error) ||
					(cmd_class == CMD_READ_TRACK && i_ev.bad_sequence))
				sector_not_found_flag <= 1'b1;
			if (is_write(cmd_class) && wp_sync[1] && !wp_prev)
				write_blocked_flag <= 1'b1;
			if (index_count == `INDEX_MISS_LIMIT || i_ev.data_mark_absent)
				mark_absent_flag <= 1'b1;
			if ((cmd_class == CMD_READ_DATA && i_ev.deleted_mark_seen) ||
					(cmd_class == CMD_READ_DELETED && i_ev.normal_mark_seen))
				control_mark_flag <= 1'b1;
			if (i_ev.data_crc_error)
				data_field_crc_flag <= 1'b1;
			if (i_ev.id_valid && i_ev.id_track != i_track) begin
				track_mismatch_flag <= 1'b1;
				if (i_ev.id_track == `BAD_TRACK_ID)
					bad_track_flag <= 1'b1;
			end
			if (i_ev.data_mark_absent)
				data_mark_absent_flag <= 1'b1;
		end
	end

	// Missing terminal count is decided in the ending cycle itself, so the latch sees it
	assign end_cyl_now = phase == ST_EXEC && i_cmd_end && !term_count_seen &&
		!i_terminal_count_input && (is_read(cmd_class) || cmd_class == CMD_WRITE_DATA ||
		cmd_class == CMD_WRITE_DELETED);

	// Any latched fault makes the ending abnormal
	assign any_error = end_cylinder_flag | end_cyl_now | crc_fault_flag | overrun_flag |
		sector_not_found_flag | write_blocked_flag | mark_absent_flag |
		equipment_fault_flag | track_mismatch_flag | data_mark_absent_flag;

	always_comb begin
		st0 = 8'h00;
		st1 = 8'h00;
		st2 = 8'h00;
		// Termination code by priority: invalid, polling, fault, normal
		if (i_invalid)
			st0[`TERM_FIELD] = `TERM_INVALID;
		else if (i_poll_abort)
			st0[`TERM_FIELD] = `TERM_POLLING;
		else if (any_error)
			st0[`TERM_FIELD] = `TERM_ABNORMAL;
		else
			st0[`TERM_FIELD] = `TERM_NORMAL;
		st0[`BIT_SEEK_DONE]   = seek_done_flag;
		st0[`BIT_EQUIP]       = equipment_fault_flag;
		st0[`BIT_HEAD]        = i_head;
		st0[`DRIVE_FIELD]     = i_drive;
		st1[`BIT_END_CYL]     = end_cylinder_flag | end_cyl_now;
		st1[`BIT_CRC]         = crc_fault_flag;
		st1[`BIT_OVERRUN]     = overrun_flag;
		st1[`BIT_NO_SECTOR]   = sector_not_found_flag;
		st1[`BIT_WRITE_BLK]   = write_blocked_flag;
		st1[`BIT_MARK_ABSENT] = mark_absent_flag;
		st2[`BIT_CTRL_MARK]   = control_mark_flag;
		st2[`BIT_DATA_CRC]    = data_field_crc_flag;
		st2[`BIT_TRACK_MISM]  = track_mismatch_flag;
		st2[`BIT_BAD_TRACK]   = bad_track_flag;
		st2[`BIT_DATA_MARK]   = data_mark_absent_flag;
		next_bytes = '{zero: st0, one: st1, two: st2};
	end

	// Latched copies held through the result phase
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_result_status_zero <= 8'h00;
			o_result_status_one  <= 8'h00;
			o_result_status_two  <= 8'h00;
		end else if (phase == ST_EXEC && i_cmd_end) begin
			o_result_status_zero <= st0;
			o_result_status_one  <= st1;
			o_result_status_two  <= st2;
		end
	end

	result_byte_store u_store (
		.i_clk   (i_clk),
		.i_nrst  (i_nrst),
		.i_load  (phase == ST_EXEC && i_cmd_end),
		.i_bytes (next_bytes),
		.i_index (i_rd_data ? rd_index + 2'h1 : rd_index),
		.o_data  (o_data)
	);

	// Host may read while result bytes remain
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_request_for_master_bit <= 1'b0;
			o_transfer_direction_bit <= 1'b0;
		end else begin
			o_request_for_master_bit <= (phase == ST_EXEC && i_cmd_end) ||
				(phase == ST_RESULT &&
				!(i_rd_data && rd_index == `RESULT_COUNT - 2'h1));
			o_transfer_direction_bit <= (phase == ST_EXEC && i_cmd_end) ||
				(phase == ST_RESULT &&
				!(i_rd_data && rd_index == `RESULT_COUNT - 2'h1));
		end
	end
endmodule

/* File: core/recal_step_counter.sv */
// Counts recalibrate step pulses and flags a missing track zero
`timescale 1ns/1ps
`include "fdc_status_map.svh"
module recal_step_counter (
	input  wire logic i_clk,        // Controller clock
	input  wire logic i_nrst,       // Async reset, active low
	input  wire logic i_clear,      // New command starts
	input  wire logic i_recal,      // Recalibrate in progress
	input  wire logic i_step,       // Step pulse issued
	input  wire logic i_track_zero, // Synchronised track zero level
	output logic      o_fault       // Limit reached without track zero
);
	logic [7:0] steps;

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			steps <= 8'h00;
		end else if (i_clear || !i_recal || i_track_zero) begin
			steps <= 8'h00;
		end else if (i_step && steps != `RECAL_STEP_LIMIT) begin
			steps <= steps + 8'h01;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_fault <= 1'b0;
		end else begin
			o_fault <= i_recal && !i_track_zero && steps == `RECAL_STEP_LIMIT;
		end
	end
endmodule

/* File: core/result_byte_store.sv */
// Three-entry result byte store with registered read data
`timescale 1ns/1ps
module result_byte_store
	import fdc_status_pkg::*;
(
	input  wire logic          i_clk,   // Controller clock
	input  wire logic          i_nrst,  // Async reset, active low
	input  wire logic          i_load,  // Capture all bytes
	input  wire status_bytes_t i_bytes, // Bytes to capture
	input  wire logic [1:0]    i_index, // Byte to present
	output logic [7:0]         o_data   // Registered read data
);
	status_bytes_t store;

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			store <= '0;
		end else if (i_load) begin
			store <= i_bytes;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_data <= 8'h00;
		end else begin
			case (i_index)
				2'h0:    o_data <= store.zero;
				2'h1:    o_data <= store.one;
				2'h2:    o_data <= store.two;
				default: o_data <= 8'h00;
			endcase
		end
	end
endmodule
